// *** rtl/sdram_pkg.sv ***
// Shared constants and types for the synchronous DRAM device core.
package sdram_pkg;
  localparam int DQ_W = 16;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int AUTO_PRE_BIT = 10;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_LAT_LSB = 4;
  localparam int MODE_FIELD_W = 3;
  localparam logic [2:0] LAT_MIN = 3'h2;
  localparam logic [2:0] LAT_MAX = 3'h3;
  localparam logic [2:0] LAT_RESET = 3'h3;
  localparam logic [2:0] BL_RESET = 3'h0;
  localparam int LAT_STAGES = 3;
  localparam int DQZ_CYCLES = 2;
  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_BURST_STOP = 4'h6;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } cmd_pins_s;

  typedef struct packed {
    logic valid;
    logic [DQ_W-1:0] data;
  } rd_word_s;

  typedef enum logic [1:0] {
    BURST_IDLE,
    BURST_READ,
    BURST_WRITE
  } burst_e;
endpackage

// *** rtl/sdram_delay_line.sv ***
// Clock-enabled register chain with a selectable output stage.
module sdram_delay_line #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_en,
  // Data
  input wire logic [WIDTH-1:0] i_data,
  input wire logic [$clog2(DEPTH)-1:0] i_sel,
  output logic [WIDTH-1:0] o_tap
);
  logic [WIDTH-1:0] stage_reg [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_reg[i] <= '0;
      end
    end else if (i_en) begin
      stage_reg[0] <= i_data;
      for (int i = 1; i < DEPTH; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  assign o_tap = stage_reg[i_sel];
endmodule

// *** rtl/sdram_device_core.sv ***
// Command decode, bursts, clock suspend and data pins of the DRAM device.
// Summary of operation
// - Column command accepted every clock cycle.
// - Clock enable low freezes from next clock.
// - Clock enable high resumes on next clock.
// - Write mask blocks same-cycle input word.
// - Read mask floats lanes two clocks later.
// - First write word taken with command.
// - Precharge floats read outputs after latency.
module sdram_device_core
  import sdram_pkg::*;
#(
  parameter int ROW_BITS = 2,
  parameter int COL_BITS = 3
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Command pins
  input wire logic i_cke,
  input wire cmd_pins_s i_cmd,
  input wire logic [BANK_W-1:0] i_bank,
  input wire logic [ADDR_W-1:0] i_addr,
  // Data pins
  input wire logic [LANES-1:0] i_dqm,
  input wire logic [DQ_W-1:0] i_dq,
  output logic [DQ_W-1:0] o_dq,
  output logic [LANES-1:0] o_dq_oe,
  // Status
  output logic o_suspended,
  output logic o_self_refresh,
  output logic [NUM_BANKS-1:0] o_bank_open,
  output logic [2:0] o_read_latency_setting
);
  localparam int IDX_W = BANK_W + ROW_BITS + COL_BITS;
  localparam int WORDS = 1 << IDX_W;

  logic cke_prev_reg;
  logic self_ref_reg;
  logic [2:0] read_latency_setting_reg;
  logic [2:0] bl_code_reg;
  logic [NUM_BANKS-1:0] bank_open_reg;
  logic [ROW_BITS-1:0] open_row_reg [NUM_BANKS];
  logic [DQ_W-1:0] mem_reg [WORDS];
  burst_e burst_reg;
  logic [2:0] left_reg;
  logic [COL_BITS-1:0] col_reg;
  logic [BANK_W-1:0] bbank_reg;
  logic bauto_reg;

  // Edges are acted on only when clock enable was high one edge earlier.
  wire logic en;
  wire logic cs;
  wire logic [3:0] code;
  wire logic cmd_rd;
  wire logic cmd_wr;
  wire logic cmd_act;
  wire logic cmd_pre;
  wire logic cmd_ref;
  wire logic cmd_lmr;
  wire logic cmd_stop;
  wire logic col_start;
  wire logic pre_hits;
  wire logic stop_burst;
  wire logic cont;
  wire logic acc_rd;
  wire logic acc_wr;
  wire logic [BANK_W-1:0] acc_bank;
  wire logic [COL_BITS-1:0] acc_col;
  wire logic [IDX_W-1:0] acc_idx;
  wire logic [2:0] bl_last;
  wire logic [2:0] new_lat;
  wire logic lat_ok;
  wire logic [1:0] lat_sel;
  wire rd_word_s rd_in;
  wire rd_word_s rd_tap;
  wire logic [LANES-1:0] dqm_tap;

  assign en = cke_prev_reg;
  assign cs = ~i_cmd.cs_n;
  assign code = {i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n, 1'b0} >> 1;
  assign cmd_rd = en & cs & (code == CMD_READ);
  assign cmd_wr = en & cs & (code == CMD_WRITE);
  assign cmd_act = en & cs & (code == CMD_ACTIVE);
  assign cmd_pre = en & cs & (code == CMD_PRECHARGE);
  assign cmd_ref = en & cs & (code == CMD_REFRESH);
  assign cmd_lmr = en & cs & (code == CMD_LOAD_MODE);
  assign cmd_stop = en & cs & (code == CMD_BURST_STOP);
  assign col_start = cmd_rd | cmd_wr;
  assign pre_hits = cmd_pre & (i_addr[AUTO_PRE_BIT] | (i_bank == bbank_reg));
  assign stop_burst = cmd_stop | pre_hits;
  assign cont = en & (burst_reg != BURST_IDLE) & (left_reg != 3'h0)
              & ~stop_burst;
  assign acc_rd = cmd_rd | (cont & (burst_reg == BURST_READ));
  assign acc_wr = cmd_wr | (cont & (burst_reg == BURST_WRITE));
  assign acc_bank = col_start ? i_bank : bbank_reg;
  assign acc_col = col_start ? i_addr[COL_BITS-1:0]
                             : COL_BITS'(col_reg + 1'b1);
  assign acc_idx = {acc_bank, open_row_reg[acc_bank], acc_col};
  assign bl_last = (bl_code_reg == 3'h0) ? 3'h0 :
                   (bl_code_reg == 3'h1) ? 3'h1 :
                   (bl_code_reg == 3'h2) ? 3'h3 : 3'h7;
  assign new_lat = i_addr[MODE_LAT_LSB +: MODE_FIELD_W];
  assign lat_ok = (new_lat == LAT_MIN) | (new_lat == LAT_MAX);
  // Tap k shows a word k+1 edges after its command, so latency n uses n-1.
  assign lat_sel = 2'(read_latency_setting_reg - LAT_MIN + 3'h1);

  // Clock enable sample and low-power states.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cke_prev_reg <= 1'b1;
      self_ref_reg <= 1'b0;
    end else begin
      cke_prev_reg <= i_cke;
      if (cmd_ref & ~i_cke) begin
        self_ref_reg <= 1'b1;
      end else if (i_cke) begin
        self_ref_reg <= 1'b0;
      end
    end
  end

  // Mode register and open-row bookkeeping.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      read_latency_setting_reg <= LAT_RESET;
      bl_code_reg <= BL_RESET;
      bank_open_reg <= '0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        open_row_reg[b] <= '0;
      end
    end else begin
      if (cmd_lmr) begin
        bl_code_reg <= i_addr[MODE_BL_LSB +: MODE_FIELD_W];
        if (lat_ok) begin
          read_latency_setting_reg <= new_lat;
        end
      end
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (cmd_act & (i_bank == BANK_W'(b))) begin
          bank_open_reg[b] <= 1'b1;
          open_row_reg[b] <= i_addr[ROW_BITS-1:0];
        end else if (cmd_pre & (i_addr[AUTO_PRE_BIT] |
                                (i_bank == BANK_W'(b)))) begin
          bank_open_reg[b] <= 1'b0;
        end else if (en & bauto_reg & (burst_reg != BURST_IDLE) &
                     ~col_start & ~cont & (bbank_reg == BANK_W'(b))) begin
          bank_open_reg[b] <= 1'b0;
        end
      end
    end
  end

  // Burst sequencing.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      burst_reg <= BURST_IDLE;
      left_reg <= 3'h0;
      col_reg <= '0;
      bbank_reg <= '0;
      bauto_reg <= 1'b0;
    end else if (en) begin
      case (burst_reg)
        BURST_IDLE, BURST_READ, BURST_WRITE: begin
          if (col_start) begin
            burst_reg <= cmd_rd ? BURST_READ : BURST_WRITE;
            left_reg <= bl_last;
            col_reg <= i_addr[COL_BITS-1:0];
            bbank_reg <= i_bank;
            bauto_reg <= i_addr[AUTO_PRE_BIT];
          end else if (cont) begin
            left_reg <= left_reg - 3'h1;
            col_reg <= acc_col;
          end else begin
            burst_reg <= BURST_IDLE;
            bauto_reg <= 1'b0;
          end
        end
        default: begin
          burst_reg <= BURST_IDLE;
        end
      endcase
    end
  end

  // Storage write with per-lane mask.
  always_ff @(posedge i_clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (acc_wr & ~i_dqm[l]) begin
        mem_reg[acc_idx][l*LANE_W +: LANE_W] <= i_dq[l*LANE_W +: LANE_W];
      end
    end
  end

  assign rd_in = '{valid: acc_rd, data: mem_reg[acc_idx]};

  // Read words appear one latency after the column command.
  sdram_delay_line #(
    .WIDTH($bits(rd_word_s)),
    .DEPTH(LAT_STAGES)
  ) u_rd_pipe (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_en(en),
    .i_data(rd_in),
    .i_sel(lat_sel),
    .o_tap(rd_tap)
  );

  sdram_delay_line #(
    .WIDTH(LANES),
    .DEPTH(DQZ_CYCLES)
  ) u_dqm_pipe (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_en(en),
    .i_data(i_dqm),
    .i_sel(1'(DQZ_CYCLES - 1)),
    .o_tap(dqm_tap)
  );

  assign o_dq = rd_tap.data;
  assign o_dq_oe = {LANES{rd_tap.valid}} & ~dqm_tap;
  assign o_suspended = ~cke_prev_reg;
  assign o_self_refresh = self_ref_reg;
  assign o_bank_open = bank_open_reg;
  assign o_read_latency_setting = read_latency_setting_reg;
endmodule

// *** tb/sdram_device_core_asserts.sv ***
// Timing checker bound to the DRAM device core.
module sdram_device_core_asserts
  import sdram_pkg::*;
(
  // Watched pins
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cke,
  input wire cmd_pins_s i_cmd,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [LANES-1:0] i_dqm,
  input wire logic [LANES-1:0] o_dq_oe,
  input wire logic o_suspended,
  input wire logic [2:0] o_read_latency_setting
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic en, rd, pre, l2;
  assign en = !o_suspended && !i_sys_rst;
  assign rd = en && i_cmd == CMD_READ && i_dqm == 2'h0;
  assign pre = en && i_cmd == CMD_PRECHARGE && i_addr[AUTO_PRE_BIT];
  assign l2 = o_read_latency_setting == 3'h2;
  chk_susp_entry: assert property (!i_cke |=> o_suspended)
    else $error("suspend not entered");
  chk_susp_exit: assert property (i_cke |=> !o_suspended)
    else $error("suspend not left");
  chk_read_b2b: assert property ((rd && l2) ##1 (rd && l2) ##1 en
    |-> o_dq_oe == 2'h3 ##1 o_dq_oe == 2'h3) else $error("read word lost");
  chk_read_cl3: assert property ((rd && !l2) ##1 (en && i_dqm == 2'h0)
    ##1 en |=> o_dq_oe == 2'h3) else $error("late read word lost");
  chk_mask_float: assert property (en && i_dqm[0] ##1 en
    |=> !o_dq_oe[0]) else $error("masked lane driven");
  chk_pre_float2: assert property ((pre && l2) ##1 en
    |=> o_dq_oe == 2'h0) else $error("driven after precharge");
  chk_pre_float3: assert property ((pre && !l2) ##1 en [*2]
    |=> o_dq_oe == 2'h0) else $error("driven after precharge");
  cover property (rd && l2);
  cover property (pre);
  cover property (!i_cke);
  cover property (en && i_cmd == CMD_BURST_STOP);
endmodule
bind sdram_device_core sdram_device_core_asserts chk (.i_clk, .i_sys_rst,
  .i_cke, .i_cmd, .i_addr, .i_dqm, .o_dq_oe, .o_suspended,
  .o_read_latency_setting);

// *** tb/sdram_host_model.sv ***
// Host controller model that drives the device pins.
module sdram_host_model
  import sdram_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Device pins
  output logic o_cke,
  output cmd_pins_s o_cmd,
  output logic [BANK_W-1:0] o_bank,
  output logic [ADDR_W-1:0] o_addr,
  output logic [LANES-1:0] o_dqm,
  output logic [DQ_W-1:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_cke = 1'b1;
    o_cmd = 4'h7;
  end
  // Idle data lines carry inverted bits so stale values never match.
  task automatic opb(input logic [3:0] c, input logic [12:0] a,
                     input logic [15:0] d, input logic [1:0] m,
                     input logic [1:0] b);
    @(posedge i_clk);
    o_cmd <= c;
    o_bank <= b;
    o_addr <= a;
    o_dqm <= m;
    o_dq <= (c == CMD_WRITE) ? d : ~o_dq;
  endtask
  task automatic op(input logic [3:0] c, input logic [12:0] a,
                    input logic [15:0] d, input logic [1:0] m);
    opb(c, a, d, m, 2'h0);
  endtask
  task automatic nop(input int n);
    repeat (n) op(4'h7, '0, '0, '0);
  endtask
  task automatic cke(input logic v, input logic [3:0] c);
    @(posedge i_clk);
    o_cke <= v;
    o_cmd <= c;
  endtask
  // run stays inside one refresh window
  task automatic init();
    nop(1);
    repeat (2000) @(posedge i_clk);
    repeat (2) begin
      op(CMD_REFRESH, '0, '0, '0);
      nop(2);
    end
  endtask
  task automatic mode(input logic [12:0] a);
    op(CMD_LOAD_MODE, a, '0, '0);
    nop(2);
  endtask
  task automatic act();
    nop(5);
    op(CMD_ACTIVE, '0, '0, '0);
    nop(1);
  endtask
  task automatic wake();
    cke(1'b1, 4'h7);
    nop(2);
  endtask
endmodule

// *** tb/sdram_device_core_tb_top.sv ***
// Self-checking bench for the DRAM device core.
`define CHK(n, e, a) \
  begin \
    total_checks++; \
    if ((a) !== (e)) begin \
      mismatches++; \
      $display("Error %s expected %h seen %h", n, e, a); \
    end \
  end
module sdram_device_core_tb_top
  import sdram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [12:0] col;
    logic [15:0] wd;
    logic [1:0] wm;
    logic [1:0] rm;
    logic [15:0] ed;
    logic [1:0] eo;
  } row_s;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic cke, susp, sref;
  cmd_pins_s cmd;
  logic [1:0] bank, dqm, oe;
  logic [12:0] addr;
  logic [15:0] dq, rdq, lm;
  logic [3:0] bopen;
  logic [2:0] lat;
  int mismatches = 0;
  int total_checks = 0;
  row_s rows [4] = '{
    '{13'h1, 16'h1234, 2'h0, 2'h0, 16'h1234, 2'h3},
    '{13'h1, 16'hABCD, 2'h1, 2'h0, 16'hAB34, 2'h3},
    '{13'h1, 16'h5566, 2'h2, 2'h0, 16'hAB66, 2'h3},
    '{13'h1, 16'h0F0F, 2'h0, 2'h1, 16'h0F00, 2'h2}};
  always #25 i_clk = ~i_clk;
  sdram_host_model host (.i_clk, .o_cke(cke), .o_cmd(cmd), .o_bank(bank),
    .o_addr(addr), .o_dqm(dqm), .o_dq(dq));
  sdram_device_core dut (.i_clk, .i_sys_rst, .i_cke(cke), .i_cmd(cmd),
    .i_bank(bank), .i_addr(addr), .i_dqm(dqm), .i_dq(dq), .o_dq(rdq),
    .o_dq_oe(oe), .o_suspended(susp), .o_self_refresh(sref),
    .o_bank_open(bopen), .o_read_latency_setting(lat));
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #1000000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    host.init();
    #1;
    `CHK("latency", LAT_RESET, lat)
    `CHK("oe", 2'h0, oe)
    `CHK("banks", 4'h0, bopen)
    $display("reset test done");
    host.mode(13'h020);
    #1;
    `CHK("latency", LAT_MIN, lat)
    host.act();
    #1;
    `CHK("banks", 4'h1, bopen)
    for (int i = 0; i < 4; i++) begin
      host.op(CMD_WRITE, rows[i].col, rows[i].wd, rows[i].wm);
      host.op(CMD_READ, rows[i].col, '0, rows[i].rm);
      host.nop(2);
      #1;
      lm = {{8{rows[i].eo[1]}}, {8{rows[i].eo[0]}}};
      `CHK("read oe", rows[i].eo, oe)
      `CHK("read data", rows[i].ed, rdq & lm)
    end
    $display("row test done");
    host.op(CMD_WRITE, 13'h2, 16'h2222, 2'h0);
    host.op(CMD_READ, 13'h1, '0, 2'h0);
    host.op(CMD_READ, 13'h2, '0, 2'h0);
    host.nop(1);
    #1;
    `CHK("first word", 16'h0F0F, rdq)
    host.nop(1);
    #1;
    `CHK("second word", 16'h2222, rdq)
    $display("back to back test done");
    host.mode(13'h072);
    #1;
    `CHK("latency kept", LAT_MIN, lat)
    host.mode(13'h032);
    #1;
    `CHK("latency", LAT_MAX, lat)
    host.op(CMD_READ, 13'h0, '0, 2'h0);
    host.op(CMD_PRECHARGE, 13'h400, '0, 2'h0);
    host.nop(2);
    #1;
    `CHK("oe before float", 2'h3, oe)
    host.nop(1);
    #1;
    `CHK("oe after float", 2'h0, oe)
    `CHK("banks", 4'h0, bopen)
    $display("precharge test done");
    host.cke(1'b0, CMD_REFRESH);
    host.nop(1);
    #1;
    `CHK("suspended", 1'b1, susp)
    `CHK("self refresh", 1'b1, sref)
    host.wake();
    #1;
    `CHK("suspended", 1'b0, susp)
    `CHK("self refresh", 1'b0, sref)
    $display("suspend test done");
    host.mode(13'h022);
    host.opb(CMD_ACTIVE, '0, '0, '0, 2'h1);
    host.nop(1);
    #1;
    `CHK("banks", 4'h2, bopen)
    host.opb(CMD_WRITE, 13'h4, 16'hA0A0, 2'h0, 2'h1);
    host.nop(1);
    host.op(CMD_BURST_STOP, '0, '0, '0);
    host.opb(CMD_READ, 13'h4, '0, 2'h0, 2'h1);
    host.nop(1);
    host.op(CMD_BURST_STOP, '0, '0, '0);
    #1;
    `CHK("burst word 0", 16'hA0A0, rdq)
    host.nop(1);
    #1;
    `CHK("burst word 1", 16'h5F5F, rdq)
    host.nop(1);
    #1;
    `CHK("oe after stop", 2'h0, oe)
    host.opb(CMD_READ, 13'h4, '0, 2'h0, 2'h1);
    host.op(CMD_PRECHARGE, 13'h400, '0, 2'h0);
    host.nop(1);
    #1;
    `CHK("oe before float", 2'h3, oe)
    host.nop(1);
    #1;
    `CHK("oe after float", 2'h0, oe)
    `CHK("banks", 4'h0, bopen)
    $display("burst stop test done");
    host.act();
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1;
    `CHK("latency", LAT_RESET, lat)
    `CHK("banks", 4'h0, bopen)
    `CHK("oe", 2'h0, oe)
    `CHK("suspended", 1'b0, susp)
    $display("mid-run reset test done");
    close_out();
  end
endmodule
